// ===== rtl/dbg_host_pkg.sv
// Constants shared by the serial debug host controller
package dbg_host_pkg;
  localparam int PKT_BITS = 17;
  localparam int DATA_BITS = 16;
  // Register offsets on the Avalon slave (byte addresses)
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_TXDATA = 4'h4;
  localparam logic [3:0] OFF_RXDATA = 4'h8;
  localparam logic [3:0] OFF_STATUS = 4'hc;
  // Control register fields
  localparam int CTRL_START = 0;
  localparam int CTRL_BREAKPOINT_REQUEST_N = 1;
  localparam int CTRL_DIVLO = 8;
  // Status register fields
  localparam int STAT_BUSY = 0;
  localparam int STAT_HALTED = 1;
  localparam int STAT_CODE_LO = 4;
  // Reset values
  localparam logic [7:0] DIV_RESET = 8'h05;
  localparam logic [15:0] DATA_RESET = 16'h0000;
  // Link timing, in system clocks
  localparam int HALF_MIN = 5;
  localparam int GAP_CYCLES = 32;
  // Halt recognition on the trace status bus
  localparam int HALT_NIBBLES = 9;
  localparam int HALT_BYTES = 5;
  localparam logic [7:0] HALT_BYTE = 8'hff;
  localparam logic [3:0] HALT_NIB = 4'hf;
  // Response words
  localparam logic [15:0] RESP_OK = 16'hffff;
  localparam logic [15:0] RESP_NOT_READY = 16'h0000;
  localparam logic [15:0] RESP_BUS_ERR = 16'h0001;
  localparam logic [15:0] RESP_ILLEGAL = 16'hffff;
  // Command word fields
  localparam int OPC_HI = 15;
  localparam int OPC_LO = 10;
  localparam int DIR_BIT = 8;
  localparam int SIZE_HI = 7;
  localparam int SIZE_LO = 6;
  typedef enum logic [2:0] {
    RSP_VALID, RSP_OK, RSP_NOT_READY, RSP_BUS_ERR, RSP_ILLEGAL, RSP_OTHER
  } resp_type;
endpackage : dbg_host_pkg

// ===== rtl/pin_sync.sv
// Two-flop synchroniser for asynchronous input pins
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_reg;
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      meta_reg <= '0;
      o_sync <= '0;
    end else begin
      meta_reg <= i_async;
      o_sync <= meta_reg;
    end
  end
endmodule : pin_sync

// ===== rtl/halt_detect.sv
// Counts halt nibbles and bytes on the trace status bus
`timescale 1ns/1ps
module halt_detect
  import dbg_host_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_edge,
  input wire logic [7:0] i_trace_status_data,
  output logic o_halted
);
  logic [3:0] nib_cnt_reg;
  logic [3:0] nib_cnt_next;
  logic [2:0] byte_cnt_reg;
  logic [2:0] byte_cnt_next;
  logic lo_f;
  logic byte_f;
  // A lone high 0xF nibble ends its run at the low nibble anyway
  assign lo_f = i_trace_status_data[3:0] == HALT_NIB;
  assign byte_f = i_trace_status_data == HALT_BYTE;
  // Running nibble count, high nibble before low in time
  always_comb begin
    nib_cnt_next = nib_cnt_reg;
    if (i_edge) begin
      if (byte_f) begin
        nib_cnt_next = (nib_cnt_reg >= 4'(HALT_NIBBLES - 2)) ?
          4'(HALT_NIBBLES) : nib_cnt_reg + 4'd2;
      end else if (lo_f) begin
        nib_cnt_next = 4'd1;
      end else begin
        nib_cnt_next = 4'd0;
      end
    end
  end
  always_comb begin
    byte_cnt_next = byte_cnt_reg;
    if (i_edge) begin
      if (!byte_f) begin
        byte_cnt_next = 3'd0;
      end else if (byte_cnt_reg < 3'(HALT_BYTES)) begin
        byte_cnt_next = byte_cnt_reg + 3'd1;
      end
    end
  end
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      nib_cnt_reg <= '0;
      byte_cnt_reg <= '0;
    end else begin
      nib_cnt_reg <= nib_cnt_next;
      byte_cnt_reg <= byte_cnt_next;
    end
  end
  assign o_halted = (nib_cnt_reg >= 4'(HALT_NIBBLES)) ||
    (byte_cnt_reg >= 3'(HALT_BYTES));
  halt_on_edge_a: assert property (@(posedge i_clk)
    disable iff (!i_reset_n)
    !$past(i_edge) |-> $stable(o_halted))
    else $error("halt flag moved without a trace clock edge");
endmodule : halt_detect

// ===== rtl/dbg_serial_host.sv
// Serial debug host: Avalon slave that drives the debug link pins
`timescale 1ns/1ps
module dbg_serial_host
  import dbg_host_pkg::*;
#(
  parameter int GAP = GAP_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output logic o_debug_serial_clock,
  output logic o_debug_serial_in,
  input wire logic i_debug_serial_out,
  input wire logic i_trace_clock,
  input wire logic [7:0] i_trace_status_data,
  output logic o_breakpoint_request_n
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_SETUP, ST_HIGH, ST_LOW, ST_GAP
  } state_type;
  state_type state_reg;
  state_type state_next;
  logic [9:0] sync_out;
  logic dso_s;
  logic tclk_s;
  logic [7:0] tsd_s;
  logic tclk_d_reg;
  logic tclk_rise;
  logic halted;
  logic [7:0] div_reg;
  logic breakpoint_request_n_reg;
  logic [15:0] tx_reg;
  logic [16:0] shift_out_reg;
  logic [16:0] shift_out_next;
  logic [16:0] rx_reg;
  logic [16:0] rx_next;
  logic [16:0] rx_last_reg;
  logic [4:0] bit_cnt_reg;
  logic [4:0] bit_cnt_next;
  logic [7:0] tmr_reg;
  logic [7:0] tmr_next;
  logic sclk_reg;
  logic sclk_next;
  logic busy;
  logic start;
  logic wr_ctrl;
  logic wr_tx;
  logic addr_ok;
  logic [7:0] half_len;
  resp_type resp_code;
  logic [31:0] status_word;
  logic [31:0] rd_mux;
  logic [7:0] gap_len;
  logic rd_done_reg;
  logic rd_take;

  pin_sync #(.WIDTH(10)) u_sync (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_async({i_debug_serial_out, i_trace_clock, i_trace_status_data}),
    .o_sync(sync_out)
  );
  assign dso_s = sync_out[9];
  assign tclk_s = sync_out[8];
  assign tsd_s = sync_out[7:0];
  assign tclk_rise = tclk_s && !tclk_d_reg;

  halt_detect u_halt (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_edge(tclk_rise),
    .i_trace_status_data(tsd_s),
    .o_halted(halted)
  );

  // Decodes a response packet into its meaning
  function automatic resp_type decode_resp(input logic [16:0] pkt);
    resp_type r;
    r = RSP_OTHER;
    if (!pkt[16]) begin
      r = (pkt[15:0] == RESP_OK) ? RSP_OK : RSP_VALID;
    end else if (pkt[15:0] == RESP_NOT_READY) begin
      r = RSP_NOT_READY;
    end else if (pkt[15:0] == RESP_BUS_ERR) begin
      r = RSP_BUS_ERR;
    end else if (pkt[15:0] == RESP_ILLEGAL) begin
      r = RSP_ILLEGAL;
    end
    return r;
  endfunction : decode_resp
  assign resp_code = decode_resp(rx_last_reg);

  // Reads wait one cycle so the registered data stands at the answer edge
  assign rd_take = i_avs_read && !rd_done_reg;
  assign o_avs_waitrequest = rd_take;
  assign addr_ok = i_avs_address[1:0] == 2'b00;
  assign wr_ctrl = i_avs_write && addr_ok && i_avs_address == OFF_CTRL;
  assign wr_tx = i_avs_write && addr_ok && i_avs_address == OFF_TXDATA;
  assign start = wr_ctrl && i_avs_writedata[CTRL_START] && !busy;
  assign busy = state_reg != ST_IDLE;
  // Divider below the minimum would break the one-fifth limit
  assign half_len = (div_reg < 8'(HALF_MIN)) ? 8'(HALF_MIN) : div_reg;
  assign gap_len = 8'(GAP);
  assign status_word = {25'h000_0000, resp_code, 2'b00, halted, busy};
  assign rd_mux = (i_avs_address == OFF_CTRL) ?
      {16'h0000, div_reg, 6'h00, breakpoint_request_n_reg, 1'b0} :
    (i_avs_address == OFF_TXDATA) ? {16'h0000, tx_reg} :
    (i_avs_address == OFF_RXDATA) ? {15'h0000, rx_last_reg} :
    (i_avs_address == OFF_STATUS) ? status_word : 32'h0000_0000;

  always_comb begin
    state_next = state_reg;
    shift_out_next = shift_out_reg;
    rx_next = rx_reg;
    bit_cnt_next = bit_cnt_reg;
    tmr_next = tmr_reg;
    sclk_next = sclk_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (start) begin
          shift_out_next = {1'b0, tx_reg};
          bit_cnt_next = 5'(PKT_BITS);
          tmr_next = half_len;
          state_next = ST_SETUP;
        end
      end
      ST_SETUP: begin
        // Data settles before the clock rises
        tmr_next = tmr_reg - 8'd1;
        if (tmr_reg == 8'd1) begin
          sclk_next = 1'b1;
          tmr_next = half_len;
          state_next = ST_HIGH;
        end
      end
      ST_HIGH: begin
        tmr_next = tmr_reg - 8'd1;
        if (tmr_reg == 8'd1) begin
          // Sample late so the device output has moved
          rx_next = {rx_reg[15:0], dso_s};
          sclk_next = 1'b0;
          bit_cnt_next = bit_cnt_reg - 5'd1;
          tmr_next = half_len;
          state_next = ST_LOW;
        end
      end
      ST_LOW: begin
        tmr_next = tmr_reg - 8'd1;
        if (tmr_reg == 8'd1) begin
          if (bit_cnt_reg == 5'd0) begin
            tmr_next = gap_len;
            state_next = ST_GAP;
          end else begin
            shift_out_next = {shift_out_reg[15:0], 1'b0};
            tmr_next = half_len;
            state_next = ST_SETUP;
          end
        end
      end
      ST_GAP: begin
        tmr_next = tmr_reg - 8'd1;
        if (tmr_reg == 8'd1) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_reg <= ST_IDLE;
      shift_out_reg <= '0;
      rx_reg <= '0;
      bit_cnt_reg <= '0;
      tmr_reg <= '0;
      sclk_reg <= 1'b0;
      tclk_d_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      shift_out_reg <= shift_out_next;
      rx_reg <= rx_next;
      bit_cnt_reg <= bit_cnt_next;
      tmr_reg <= tmr_next;
      sclk_reg <= sclk_next;
      tclk_d_reg <= tclk_s;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      div_reg <= DIV_RESET;
      breakpoint_request_n_reg <= 1'b0;
      tx_reg <= DATA_RESET;
      rx_last_reg <= '0;
    end else begin
      if (wr_ctrl) begin
        div_reg <= i_avs_writedata[CTRL_DIVLO +: 8];
        breakpoint_request_n_reg <= i_avs_writedata[CTRL_BREAKPOINT_REQUEST_N];
      end
      if (wr_tx && !busy) begin
        tx_reg <= i_avs_writedata[15:0];
      end
      if (state_reg == ST_LOW && state_next == ST_GAP) begin
        rx_last_reg <= rx_reg;
      end
    end
  end

  // Writes need no wait; a read is answered on its second cycle
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rd_done_reg <= 1'b0;
      o_avs_readdata <= '0;
    end else begin
      rd_done_reg <= rd_take;
      if (rd_take) begin
        o_avs_readdata <= rd_mux;
      end
    end
  end

  assign o_debug_serial_clock = sclk_reg;
  assign o_debug_serial_in = shift_out_reg[16];
  // Request line to the device; it owns
  assign o_breakpoint_request_n = !breakpoint_request_n_reg;

  // Helper: cycles the clock has stayed high
  logic [7:0] high_cnt_reg;
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      high_cnt_reg <= '0;
    end else begin
      high_cnt_reg <= sclk_reg ? high_cnt_reg + 8'd1 : 8'd0;
    end
  end

  lead_zero_a: assert property (@(posedge i_clk)
    disable iff (!i_reset_n)
    (state_reg == ST_IDLE && start) |=> !o_debug_serial_in)
    else $error("leading status bit not zero");
  clk_low_a: assert property (@(posedge i_clk)
    disable iff (!i_reset_n)
    $fell(o_debug_serial_clock) |-> ##1 !o_debug_serial_clock [*4])
    else $error("serial clock low phase too short");
  clk_high_a: assert property (@(posedge i_clk)
    disable iff (!i_reset_n)
    $fell(o_debug_serial_clock) |-> $past(high_cnt_reg) >= 8'd4)
    else $error("serial clock high phase too short");
  data_stable_a: assert property (@(posedge i_clk)
    disable iff (!i_reset_n)
    o_debug_serial_clock |-> $stable(o_debug_serial_in))
    else $error("data in changed while clock high");
  bit_count_a: assert property (@(posedge i_clk)
    disable iff (!i_reset_n)
    (state_reg == ST_IDLE && start) |=> bit_cnt_reg == 5'd17)
    else $error("packet length not seventeen");
  gap_wait_a: assert property (@(posedge i_clk)
    disable iff (!i_reset_n)
    (state_reg == ST_LOW && state_next == ST_GAP) |=>
      busy [*8])
    else $error("next transfer allowed too early");
  clock_idle_a: assert property (@(posedge i_clk)
    disable iff (!i_reset_n)
    (state_reg == ST_GAP || state_reg == ST_IDLE) |-> !o_debug_serial_clock)
    else $error("serial clock high outside packet");
  resp_err_a: assert property (@(posedge i_clk)
    disable iff (!i_reset_n)
    (rx_last_reg == 17'h1_0001) |-> resp_code == RSP_BUS_ERR)
    else $error("bus error response misdecoded");
  read_wait_a: assert property (@(posedge i_clk)
    disable iff (!i_reset_n)
    $rose(i_avs_read) |-> o_avs_waitrequest)
    else $error("read answered before its data stood");
  read_hold_a: assert property (@(posedge i_clk)
    disable iff (!i_reset_n)
    (i_avs_read && !o_avs_waitrequest) |=> $stable(o_avs_readdata))
    else $error("read data moved after the answer edge");
endmodule : dbg_serial_host

// ===== tb/dbg_device_model.sv
// Behavioural debug device: serial slave and trace status source
`timescale 1ns/1ps
module dbg_device_model (
  input wire logic i_trace_clock,
  input wire logic i_reset_n,
  input wire logic i_sclk,
  input wire logic i_sdi,
  input wire logic i_breakpoint_request_n_n,
  output logic o_sdo,
  output logic [7:0] o_trace,
  output logic [16:0] o_last_rx,
  output logic [7:0] o_packets,
  output logic [7:0] o_viol
);
  logic [2:0] sck_s;
  logic [1:0] sdi_s;
  logic [16:0] tx, rx;
  logic [4:0] pos;
  logic [3:0] hi, age;
  logic [2:0] idx;
  logic halted;
  logic [3:0] src;
  wire rise = sck_s[1] & ~sck_s[2];
  wire fall = sck_s[2] & ~sck_s[1];
  wire [15:0] word = {rx[14:0], sdi_s[1]};

  function automatic logic [16:0] reply(input logic [15:0] c,
                                        input logic h,
                                        input logic [3:0] s);
    case (c[15:10])
      6'h0b: reply = {13'h0000, s};
      6'h00, 6'h03: reply = 17'h0_ffff;
      6'h06: reply = c[8] ? 17'h0_00a5 : 17'h1_0000;
      6'h08: reply = h ? 17'h0_1234 : 17'h1_0001;
      default: reply = 17'h1_ffff;
    endcase
  endfunction : reply

  always @(posedge i_trace_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sck_s <= '0;
      sdi_s <= '0;
      tx <= 17'h1_0000;
      rx <= '0;
      pos <= 5'd16;
      hi <= '0;
      age <= '0;
      idx <= '0;
      halted <= 1'b0;
      src <= '0;
      o_sdo <= 1'b0;
      o_trace <= 8'h00;
      o_last_rx <= '0;
      o_packets <= '0;
      o_viol <= '0;
    end else begin
      sck_s <= {sck_s[1:0], i_sclk};
      sdi_s <= {sdi_s[0], i_sdi};
      hi <= sck_s[1] ? hi + 4'h1 : 4'h0;
      if (fall && hi < 4'h2) o_viol <= o_viol + 8'h01;
      if (age != 4'hf) age <= age + 4'h1;
      idx <= (idx == 3'd4) ? 3'd0 : idx + 3'd1;
      // Running pattern holds the longest legal run of 0xF nibbles
      o_trace <= halted ? 8'hff : (idx == 3'd0) ? 8'hbf :
                 (idx == 3'd4) ? 8'hf1 : 8'hff;
      if (!i_breakpoint_request_n_n && (idx == 3'd4 || age < 4'd8)) begin
        halted <= 1'b1;
        // Request ranks below fault and trigger sources
        if (src < 4'h4) src <= 4'h4;
      end
      if (rise) begin
        rx <= {rx[15:0], sdi_s[1]};
        o_sdo <= tx[pos];
        if (pos == 5'd0) begin
          pos <= 5'd16;
          o_last_rx <= {rx[15:0], sdi_s[1]};
          tx <= reply(word, halted, src);
          o_packets <= o_packets + 8'h01;
          if (word[15:10] == 6'h03) begin
            halted <= 1'b0;
            src[2:0] <= 3'h0;
          end
        end else begin
          pos <= pos - 5'd1;
        end
      end
    end
  end
endmodule : dbg_device_model

// ===== tb/tb_dbg_serial_host.sv
// Bench for the serial debug host with a device model
`timescale 1ns/1ps
module tb_dbg_serial_host;
  import dbg_host_pkg::*;
  logic clk, reset_n, rd, wr, tclk, sdo, sclk, sdi, brk_n, wait_req, breakpoint_request_n;
  logic [3:0] addr;
  logic [31:0] wdata, rdata, r;
  logic [7:0] trace, packets, viol;
  logic [16:0] last_rx;
  int err_total, check_count, cycles;
  logic [15:0] cmds [6] = '{16'h0000, 16'h1900, 16'h1800, 16'h2180,
                            16'hfc00, 16'h0000};
  logic [16:0] exps [6] = '{17'h1_0000, 17'h0_ffff, 17'h0_00a5,
                            17'h1_0000, 17'h1_0001, 17'h1_ffff};
  logic [2:0] codes [6] = '{RSP_NOT_READY, RSP_OK, RSP_VALID,
                            RSP_NOT_READY, RSP_BUS_ERR, RSP_ILLEGAL};

  dbg_serial_host u_dut (.i_clk(clk), .i_reset_n(reset_n),
    .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wdata), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wait_req), .o_debug_serial_clock(sclk),
    .o_debug_serial_in(sdi), .i_debug_serial_out(sdo),
    .i_trace_clock(tclk), .i_trace_status_data(trace),
    .o_breakpoint_request_n(brk_n));
  dbg_device_model u_dev (.i_trace_clock(tclk), .i_reset_n(reset_n),
    .i_sclk(sclk), .i_sdi(sdi), .i_breakpoint_request_n_n(brk_n), .o_sdo(sdo),
    .o_trace(trace), .o_last_rx(last_rx), .o_packets(packets),
    .o_viol(viol));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Trace clock free-runs, phase unrelated to the system clock
  initial begin
    tclk = 1'b0;
    #7;
    forever #80 tclk = ~tclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic av_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    do @(posedge clk); while (wait_req !== 1'b0);
    wr <= 1'b0;
  endtask : av_write

  task automatic av_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    do @(posedge clk); while (wait_req !== 1'b0);
    d = rdata;
    rd <= 1'b0;
  endtask : av_read

  // Half period of 40 clocks leaves the device time to sync and answer
  task automatic set_ctrl(input logic st);
    av_write(OFF_CTRL, {16'h0000, 8'h28, 6'h00, breakpoint_request_n, st});
  endtask : set_ctrl

  task automatic wait_idle(output logic [31:0] s);
    s = 32'h0000_0001;
    while (s[STAT_BUSY] !== 1'b0) av_read(OFF_STATUS, s);
  endtask : wait_idle

  task automatic xfer(input logic [15:0] c, input logic [16:0] e,
                      input logic [2:0] code);
    logic [31:0] s;
    av_write(OFF_TXDATA, {16'h0000, c});
    set_ctrl(1'b1);
    wait_idle(s);
    chk({29'h0, s[STAT_CODE_LO +: 3]}, {29'h0, code});
    av_read(OFF_RXDATA, s);
    chk(s, {15'h0000, e});
    chk({15'h0000, last_rx}, {16'h0000, c});
  endtask : xfer

  task automatic finish_test;
    $display("Counts: %0d checks, %0d errors", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test

  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      err_total++;
      finish_test;
    end
  end

  initial begin
    reset_n = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    addr = 4'h0;
    wdata = 32'h0000_0000;
    breakpoint_request_n = 1'b0;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    av_read(OFF_STATUS, r);
    chk(r, 32'h0000_0000);
    av_read(OFF_RXDATA, r);
    chk(r, 32'h0000_0000);
    av_read(4'h2, r);
    chk(r, 32'h0000_0000);
    chk({31'h0, brk_n}, 32'h0000_0001);
    $display("Test reset values done");
    for (int i = 0; i < 6; i++) xfer(cmds[i], exps[i], codes[i]);
    $display("Test response codes done");
    av_write(OFF_TXDATA, 32'h0000_0000);
    set_ctrl(1'b1);
    repeat (10) @(posedge clk);
    av_write(OFF_TXDATA, 32'h0000_fc00);
    set_ctrl(1'b1);
    wait_idle(r);
    chk({15'h0000, last_rx}, 32'h0000_0000);
    chk({24'h0, packets}, 32'h0000_0007);
    $display("Test busy refusal done");
    repeat (400) @(posedge clk);
    av_read(OFF_STATUS, r);
    chk({31'h0, r[STAT_HALTED]}, 32'h0000_0000);
    breakpoint_request_n = 1'b1;
    set_ctrl(1'b0);
    repeat (2) @(posedge clk);
    chk({31'h0, brk_n}, 32'h0000_0000);
    r = 32'h0000_0000;
    for (int n = 0; n < 100 && r[STAT_HALTED] !== 1'b1; n++)
      av_read(OFF_STATUS, r);
    chk({31'h0, r[STAT_HALTED]}, 32'h0000_0001);
    xfer(16'h2180, 17'h0_ffff, RSP_OK);
    xfer(16'h2d80, 17'h0_1234, RSP_VALID);
    breakpoint_request_n = 1'b0;
    set_ctrl(1'b0);
    xfer(16'h0c00, 17'h0_0004, RSP_VALID);
    xfer(16'h2d80, 17'h0_ffff, RSP_OK);
    xfer(16'h0000, 17'h0_0000, RSP_VALID);
    av_read(OFF_STATUS, r);
    chk({31'h0, r[STAT_HALTED]}, 32'h0000_0000);
    chk({24'h0, viol}, 32'h0000_0000);
    $display("Test halt and resume done");
    finish_test;
  end
endmodule : tb_dbg_serial_host
